// [core/edwm_consts.svh]
// constants for the extended data window page mapper
`ifndef EDWM_CONSTS_SVH
`define EDWM_CONSTS_SVH
`define EDWM_ADDR_W        16
`define EDWM_WIN_BIT       15
`define EDWM_OFS_W         15
`define EDWM_XADDR_W       24
`define EDWM_RPAGE_W       10
`define EDWM_WPAGE_W       9
`define EDWM_PAGE_FIELD_W  9
`define EDWM_RPAGE_HI_BIT  9
`define EDWM_RPAGE_RST     10'h001
`define EDWM_WPAGE_RST     9'h001
`define EDWM_INT_PAGES     9'h003
`define EDWM_RD_STALL      2'h1
`define EDWM_RPT_STALL     2'h2
`define EDWM_RPT_FIRST     2'h2
`endif

// [core/edwm_mapper.sv]
// extended data window page mapper top level
//
// Overview of operation
// - extended space split into 32 Kbyte pages
// - upper half window is only access path
// - read page 10 bits, write page 9
// - effective address bit 15 selects window
// - read address is page bits above offset
// - page zero through window raises trap
// - page zero is base lower memory
// - windowed read costs one extra cycle
// - repeated reads: first two three cycles
// - route to internal, external or visibility
// - write address is page bits above offset
// - windowed writes complete in one cycle
// - page registers hold across pointer wrap
// - below window, pages ignored, direct access
`timescale 1ns/1ps
`default_nettype none
`include "edwm_consts.svh"
module edwm_mapper
    import edwm_pkg::*;
#(
    parameter int       RPAGE_W   = `EDWM_RPAGE_W,
    parameter int       WPAGE_W   = `EDWM_WPAGE_W,
    parameter logic [8:0] INT_PAGES = `EDWM_INT_PAGES
) (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    // page register loads from the core
    input  wire logic                      rpage_we,
    input  wire logic [RPAGE_W-1:0]        rpage_wdata,
    input  wire logic                      wpage_we,
    input  wire logic [WPAGE_W-1:0]        wpage_wdata,
    // access request from address generation
    input  wire logic                      acc_valid,
    input  wire logic                      acc_write,
    input  wire logic                      acc_repeat,
    input  wire logic [`EDWM_ADDR_W-1:0]   effective_addr,
    // handshake and translated result for the load/store path
    output logic                           acc_ready,
    output logic                           xaddr_valid,
    output logic [`EDWM_XADDR_W-1:0]       xaddr,
    output edwm_dest_t                     xdest,
    output logic                           addr_trap,
    // current page values, visible to the core
    output logic [RPAGE_W-1:0]             read_page_select,
    output logic [WPAGE_W-1:0]             write_page_select
);
    logic                          in_window;
    logic [`EDWM_PAGE_FIELD_W-1:0] page;
    logic                          vis_sel;
    logic                          page_zero;
    logic [1:0]                    stall_cnt;
    logic [1:0]                    rpt_count;
    logic                          rd_win;
    logic                          take;
    logic [1:0]                    next_stall;

    // joins a page with the window offset into an extended address
    function automatic logic [`EDWM_XADDR_W-1:0] edwm_join(
        input logic [`EDWM_PAGE_FIELD_W-1:0] pg,
        input logic [`EDWM_ADDR_W-1:0]       addr
    );
        edwm_join = {pg, addr[`EDWM_OFS_W-1:0]};
    endfunction

    // page zero through the window is base memory; it must trap
    function automatic logic edwm_hits_base(
        input logic                          win,
        input logic                          vis,
        input logic [`EDWM_PAGE_FIELD_W-1:0] pg
    );
        edwm_hits_base = win && !vis && (pg == '0);
    endfunction

    // picks where a translated access goes; lower space wins over pages
    function automatic edwm_dest_t edwm_route(
        input logic                          win,
        input logic                          vis,
        input logic [`EDWM_PAGE_FIELD_W-1:0] pg,
        input logic [`EDWM_PAGE_FIELD_W-1:0] split
    );
        if (!win) begin
            edwm_route = EDWM_DST_LOWER;
        end else if (vis) begin
            edwm_route = EDWM_DST_VISIBLE;
        end else if (pg < split) begin
            edwm_route = EDWM_DST_INTERNAL;
        end else begin
            edwm_route = EDWM_DST_EXTERNAL;
        end
    endfunction

    // page registers sit apart; only explicit core writes move them
    edwm_page_regs #(
        .RPAGE_W (RPAGE_W),
        .WPAGE_W (WPAGE_W)
    ) u_pages (
        .core_clk          (core_clk),
        .resetn            (resetn),
        .rpage_we          (rpage_we),
        .rpage_wdata       (rpage_wdata),
        .wpage_we          (wpage_we),
        .wpage_wdata       (wpage_wdata),
        .read_page_select  (read_page_select),
        .write_page_select (write_page_select)
    );

    // window decode and page choice by direction
    assign in_window = effective_addr[`EDWM_WIN_BIT];
    assign page      = acc_write ? write_page_select[8:0]
                                 : read_page_select[8:0];
    // read page top bit set means program space visibility, not a page
    assign vis_sel   = !acc_write
                     && read_page_select[`EDWM_RPAGE_HI_BIT];
    assign page_zero = edwm_hits_base(in_window, vis_sel, page);
    assign rd_win    = acc_valid && !acc_write && in_window;

    // reads in the window wait; writes never do
    // timing of one access, counted from the cycle acc_valid first stands:
    //   write or lower read   : ready at once, answer in the next cycle
    //   window read           : one extra cycle, ready in the second
    //   first two repeat reads: two extra cycles, ready in the third
    //   later repeat reads    : no extra cycle, the fetch pipe is full
    // a trapped access takes no stall, so the trap follows at once
    always_comb begin
        next_stall = 2'h0;
        if (rd_win && !page_zero) begin
            if (acc_repeat && rpt_count >= `EDWM_RPT_FIRST) begin
                next_stall = 2'h0;
            end else if (acc_repeat) begin
                next_stall = `EDWM_RPT_STALL;
            end else begin
                next_stall = `EDWM_RD_STALL;
            end
        end
    end

    // stall counter: new read loads it, zero means access may finish
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stall_cnt <= 2'h0;
        end else if (stall_cnt != 2'h0) begin
            stall_cnt <= stall_cnt - 2'h1;
        end else if (acc_valid && next_stall != 2'h0 && !take) begin
            stall_cnt <= next_stall - 2'h1;
        end
    end

    // a read is only taken once its extra cycles have run out
    logic pend;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'b0;
        end else if (take) begin
            pend <= 1'b0;
        end else if (acc_valid && next_stall != 2'h0 && stall_cnt == 2'h0) begin
            pend <= 1'b1;
        end
    end
    // ready is combinational so a write completes in the cycle it is
    // asked; a registered ready would cost every write a second cycle
    assign take = acc_valid && stall_cnt == 2'h0
                && (pend || next_stall == 2'h0);
    assign acc_ready = take;

    // count reads in a repeat run; the first two pay the long stall
    // the count saturates so a long loop never wraps back to slow reads;
    // any other access or a dropped repeat flag starts the run over
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rpt_count <= 2'h0;
        end else if (take && rd_win && acc_repeat) begin
            if (rpt_count != `EDWM_RPT_FIRST) begin
                rpt_count <= rpt_count + 2'h1;
            end
        end else if (take || !acc_repeat) begin
            rpt_count <= 2'h0;
        end
    end

    // access-done pulse: one cycle after a take that did not trap
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xaddr_valid <= 1'b0;
        end else begin
            xaddr_valid <= take && !page_zero;
        end
    end

    // trap pulse: a page zero hit through the window never completes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_trap <= 1'b0;
        end else begin
            addr_trap <= take && page_zero;
        end
    end

    // extended address; holds until the next take so late readers see it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xaddr <= 24'h000000;
        end else if (take) begin
            if (!in_window) begin
                xaddr <= {8'h00, effective_addr};
            end else begin
                xaddr <= edwm_join(page, effective_addr);
            end
        end
    end

    // destination decode for the load/store path
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xdest <= EDWM_DST_LOWER;
        end else if (take) begin
            xdest <= edwm_route(in_window, vis_sel, page,
                                INT_PAGES);
        end
    end
endmodule
`default_nettype wire

// [core/edwm_page_regs.sv]
// read-page and write-page select registers
`timescale 1ns/1ps
`default_nettype none
`include "edwm_consts.svh"
module edwm_page_regs #(
    parameter int RPAGE_W = `EDWM_RPAGE_W,
    parameter int WPAGE_W = `EDWM_WPAGE_W
) (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               rpage_we,
    input  wire logic [RPAGE_W-1:0] rpage_wdata,
    input  wire logic               wpage_we,
    input  wire logic [WPAGE_W-1:0] wpage_wdata,
    output logic      [RPAGE_W-1:0] read_page_select,
    output logic      [WPAGE_W-1:0] write_page_select
);
    // only an explicit core write changes a page; pointer wrap never does
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            read_page_select <= RPAGE_W'(`EDWM_RPAGE_RST);
        end else if (rpage_we) begin
            read_page_select <= rpage_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            write_page_select <= WPAGE_W'(`EDWM_WPAGE_RST);
        end else if (wpage_we) begin
            write_page_select <= wpage_wdata;
        end
    end
endmodule
`default_nettype wire

// [core/edwm_pkg.sv]
// types for the extended data window page mapper
package edwm_pkg;
    typedef enum logic [1:0] {
        EDWM_DST_LOWER,
        EDWM_DST_INTERNAL,
        EDWM_DST_EXTERNAL,
        EDWM_DST_VISIBLE
    } edwm_dest_t;
endpackage

// [test/edwm_core_model.sv]
// core-side load/store model, holds each request until taken
`timescale 1ns/1ps
`default_nettype none
module edwm_core_model (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic        w,
    input  wire logic        r,
    input  wire logic [15:0] a,
    input  wire logic        acc_ready,
    output logic             acc_valid,
    output logic             acc_write,
    output logic             acc_repeat,
    output logic [15:0]      effective_addr
);
    // released address is flipped so a stale value never looks live
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {acc_valid, acc_write, acc_repeat} <= 3'h0;
            effective_addr <= 16'hffff;
        end else if (go) begin
            {acc_valid, acc_write, acc_repeat} <= {1'b1, w, r};
            effective_addr <= a;
        end else if (acc_valid && acc_ready) begin
            acc_valid <= 1'b0;
            effective_addr <= ~effective_addr;
        end
    end
endmodule
`default_nettype wire

// [test/edwm_mapper_asserts.sv]
// port-level checks for the page mapper
`timescale 1ns/1ps
`default_nettype none
module edwm_mapper_asserts #(
    parameter int RPAGE_W = 10,
    parameter int WPAGE_W = 9
) (
    input wire logic               core_clk,
    input wire logic               resetn,
    input wire logic               rpage_we,
    input wire logic               wpage_we,
    input wire logic               acc_valid,
    input wire logic               acc_write,
    input wire logic               acc_repeat,
    input wire logic [15:0]        effective_addr,
    input wire logic               acc_ready,
    input wire logic               xaddr_valid,
    input wire logic [23:0]        xaddr,
    input wire logic               addr_trap,
    input wire logic [RPAGE_W-1:0] read_page_select,
    input wire logic [WPAGE_W-1:0] write_page_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // request taken, window hit, usable read page
    wire logic tk = acc_valid && acc_ready;
    wire logic win = effective_addr[15];
    wire logic rok = !read_page_select[9] && read_page_select[8:0] != 9'h000;
    sequence s_wait1; !acc_ready ##1 acc_ready; endsequence
    sequence s_wait2; !acc_ready [*2] ##1 acc_ready; endsequence
    // windowed repeat reads taken so far in this run, saturating at two
    logic [1:0] rpt_seen;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rpt_seen <= 2'h0;
        end else if (!acc_repeat || (tk && (acc_write || !win))) begin
            rpt_seen <= 2'h0;
        end else if (tk && rpt_seen != 2'h2) begin
            rpt_seen <= rpt_seen + 2'h1;
        end
    end
    a_trap_read: assert property (tk && win && !acc_write &&
        read_page_select == '0 |=> addr_trap && !xaddr_valid)
        else $error("no trap on page zero read");
    a_trap_zero: assert property (tk && win && acc_write &&
        write_page_select == 9'h000 |=> addr_trap && !xaddr_valid)
        else $error("no trap on page zero write");
    a_write_join: assert property (tk && win && acc_write &&
        write_page_select != 9'h000 |=> xaddr_valid && xaddr ==
        {$past(write_page_select[8:0]), $past(effective_addr[14:0])})
        else $error("write address not joined");
    a_write_single: assert property (acc_valid && acc_write |-> acc_ready)
        else $error("write stalled");
    a_lower_direct: assert property (tk && !win |=>
        xaddr == {8'h00, $past(effective_addr)}) else $error("lower wrong");
    a_read_stall: assert property ($rose(acc_valid) && !acc_write &&
        win && !acc_repeat && rok |-> s_wait1) else $error("read stall");
    a_repeat_stall: assert property ($rose(acc_valid) && !acc_write &&
        win && acc_repeat && rok && rpt_seen != 2'h2 |-> s_wait2)
        else $error("repeat stall");
    a_repeat_fast: assert property ($rose(acc_valid) && !acc_write &&
        win && acc_repeat && rok && rpt_seen == 2'h2 |-> acc_ready)
        else $error("late repeat read stalled");
    a_read_join: assert property (tk && !acc_write && win && rok |=>
        xaddr == {$past(read_page_select[8:0]), $past(effective_addr[14:0])})
        else $error("read address not joined");
    a_page_hold: assert property (!rpage_we && !wpage_we |=>
        $stable(read_page_select) && $stable(write_page_select))
        else $error("page changed without write");
endmodule
bind edwm_mapper edwm_mapper_asserts #(
    .RPAGE_W (RPAGE_W),
    .WPAGE_W (WPAGE_W)
) u_chk (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .rpage_we          (rpage_we),
    .wpage_we          (wpage_we),
    .acc_valid         (acc_valid),
    .acc_write         (acc_write),
    .acc_repeat        (acc_repeat),
    .effective_addr    (effective_addr),
    .acc_ready         (acc_ready),
    .xaddr_valid       (xaddr_valid),
    .xaddr             (xaddr),
    .addr_trap         (addr_trap),
    .read_page_select  (read_page_select),
    .write_page_select (write_page_select)
);
`default_nettype wire

// [test/edwm_mapper_tb.sv]
// self-checking bench for the page mapper
`timescale 1ns/1ps
`default_nettype none
module extended_data_page_mapper_tb;
    import edwm_pkg::*;
    logic core_clk = 0, resetn = 0, go = 0, w = 0, r = 0;
    logic rpage_we = 0, wpage_we = 0, acc_valid, acc_write, acc_repeat;
    logic acc_ready, xaddr_valid, addr_trap;
    logic [15:0] a = 16'h0000, effective_addr;
    logic [23:0] xaddr;
    logic [9:0] rpage_wdata = 10'h000, read_page_select;
    logic [8:0] wpage_wdata = 9'h000, write_page_select;
    edwm_dest_t xdest;
    int fails = 0, num_checks = 0, cyc = 0, n;
    edwm_mapper DUT (
        .core_clk          (core_clk),
        .resetn            (resetn),
        .rpage_we          (rpage_we),
        .rpage_wdata       (rpage_wdata),
        .wpage_we          (wpage_we),
        .wpage_wdata       (wpage_wdata),
        .acc_valid         (acc_valid),
        .acc_write         (acc_write),
        .acc_repeat        (acc_repeat),
        .effective_addr    (effective_addr),
        .acc_ready         (acc_ready),
        .xaddr_valid       (xaddr_valid),
        .xaddr             (xaddr),
        .xdest             (xdest),
        .addr_trap         (addr_trap),
        .read_page_select  (read_page_select),
        .write_page_select (write_page_select)
    );
    edwm_core_model u_core (
        .core_clk       (core_clk),
        .resetn         (resetn),
        .go             (go),
        .w              (w),
        .r              (r),
        .a              (a),
        .acc_ready      (acc_ready),
        .acc_valid      (acc_valid),
        .acc_write      (acc_write),
        .acc_repeat     (acc_repeat),
        .effective_addr (effective_addr)
    );
    always #12.5 core_clk = ~core_clk;
    // cut a hang short well past the roughly 60 cycles needed
    always @(posedge core_clk) if (++cyc == 3000) begin
        fails++;
        conclude();
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pages(input logic [9:0] rp, input logic [8:0] wp);
        @(posedge core_clk);
        {rpage_we, wpage_we, rpage_wdata, wpage_wdata} <= {2'b11, rp, wp};
        @(posedge core_clk);
        {rpage_we, wpage_we} <= 2'b00;
    endtask
    // one access: n counts cycles held until taken, answer a cycle later
    task automatic acc(input logic wr, rp, input logic [15:0] ad,
                       input int en, input logic [23:0] ex, input logic tr);
        @(posedge core_clk);
        {go, w, r, a} <= {1'b1, wr, rp, ad};
        @(posedge core_clk);
        go <= 1'b0;
        #1 n = 1;
        while (acc_ready !== 1'b1 && n < 9) begin
            @(posedge core_clk);
            #1 n++;
        end
        @(posedge core_clk);
        #1 chk(24'(n), 24'(en));
        chk(addr_trap, tr);
        chk(xaddr_valid, !tr);
        if (!tr) chk(xaddr, ex);
    endtask
    task automatic t_zero;
        pages(10'h000, 9'h000);
        acc(1, 0, 16'h8800, 1, 0, 1);
        acc(0, 0, 16'h8000, 1, 0, 1);
        acc(0, 0, 16'h7fff, 1, 24'h007fff, 0);
        chk(xdest, EDWM_DST_LOWER);
        $display("test page zero done");
    endtask
    task automatic t_write;
        pages(10'h1ff, 9'h002);
        acc(1, 0, 16'hffff, 1, 24'h017fff, 0);
        acc(1, 0, 16'h8000, 1, 24'h010000, 0);
        chk(write_page_select, 9'h002);
        $display("test write done");
    endtask
    task automatic t_read;
        acc(0, 0, 16'h8002, 2, 24'hff8002, 0);
        chk(xdest, EDWM_DST_EXTERNAL);
        pages(10'h002, 9'h002);
        acc(0, 0, 16'h8002, 2, 24'h010002, 0);
        chk(xdest, EDWM_DST_INTERNAL);
        acc(0, 1, 16'h8004, 3, 24'h010004, 0);
        acc(0, 1, 16'h8006, 3, 24'h010006, 0);
        acc(0, 1, 16'h8008, 1, 24'h010008, 0);
        pages(10'h003, 9'h002);
        acc(0, 0, 16'h8000, 2, 24'h018000, 0);
        chk(xdest, EDWM_DST_EXTERNAL);
        pages(10'h200, 9'h002);
        acc(0, 0, 16'h8010, 2, 24'h000010, 0);
        chk(xdest, EDWM_DST_VISIBLE);
        $display("test read done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        #1 chk(read_page_select, 10'h001);
        chk(write_page_select, 9'h001);
        t_zero();
        t_write();
        t_read();
        conclude();
    end
endmodule
`default_nettype wire
